// ===== mra_core_model.sv
// core-side model: register accesses and per-cycle check requests
`timescale 1ns/100ps
`default_nettype none
module mra_core_model (
  input wire logic clk, // core clock
  output logic [4:0] avs_address, // byte address
  output logic avs_read, // read request
  output logic avs_write, // write request
  output logic [31:0] avs_writedata, // write data
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  output logic i_req, // fetch to check
  output logic [31:0] i_addr, // fetch address
  output logic d_req, // data access to check
  output logic [31:0] d_addr, // data address
  output logic d_write, // store
  output logic [31:0] exec_pc, // executing pc
  output logic user_mode, // user mode
  output logic debug_mode, // debug
  output logic trap_req, // trap request
  output logic illegal_req, // illegal request
  output logic misalign_req // misalign request
);
  // idle values from time zero
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    i_req = 1'b0;
    i_addr = 32'h0000_0000;
    d_req = 1'b0;
    d_addr = 32'h0000_0000;
    d_write = 1'b0;
    exec_pc = 32'h0000_0200;
    user_mode = 1'b0;
    debug_mode = 1'b0;
    {trap_req, illegal_req, misalign_req} = 3'h0;
  end
  // one access, held until waitrequest is seen low; data lines scrambled after
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_writedata <= ~d;
  endtask
  // select then control write, flags chosen by caller
  task automatic region(input logic [31:0] s, input logic [31:0] c);
    logic [31:0] q;
    acc(1'b1, 5'h00, s, q);
    acc(1'b1, 5'h04, c, q);
  endtask
  // mode lines for the following check requests
  task automatic mode(input logic um, input logic dw);
    @(posedge clk);
    user_mode <= um;
    d_write <= dw;
  endtask
  // one cycle of check requests, then idle
  task automatic ex(input logic ir, input logic [31:0] ia, input logic dr,
    input logic [31:0] da, input logic [2:0] oth, input logic dbg);
    @(posedge clk);
    i_req <= ir;
    i_addr <= ia;
    d_req <= dr;
    d_addr <= da;
    {trap_req, illegal_req, misalign_req} <= oth;
    debug_mode <= dbg;
    @(posedge clk);
    i_req <= 1'b0;
    d_req <= 1'b0;
    i_addr <= ~ia;
    d_addr <= ~da;
    {trap_req, illegal_req, misalign_req} <= 3'h0;
    debug_mode <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== mra_pkg.sv
// types shared by the region access unit
`default_nettype none
package mra_pkg;
  typedef enum logic [1:0] {
    mra_bus_idle = 2'b01,
    mra_bus_done = 2'b10
  } mra_bus_state_type;
endpackage
`default_nettype wire

// ===== mra_region_store.sv
// region attribute store with per-region match and rights check
`timescale 1ns/100ps
`default_nettype none
`include "mra_regs.svh"
module mra_region_store (
  input wire logic clk, // core clock
  input wire logic srst, // sync reset
  input wire logic wr_en, // commit region attributes
  input wire logic [3:0] wr_idx, // {data select, index}
  input wire logic [25:0] wr_origin, // origin to commit
  input wire logic [25:0] wr_bound, // size code or upper bound
  input wire logic wr_cache, // cacheable flag
  input wire logic [2:0] wr_rights, // access rights
  input wire logic [3:0] rd_idx, // region to read
  output logic [25:0] rd_origin, // stored origin
  output logic [25:0] rd_bound, // stored size code or bound
  output logic rd_cache, // stored cacheable flag
  output logic [2:0] rd_rights, // stored rights
  input wire logic limit_mode, // upper-bound mode
  input wire logic user_mode, // core in user mode
  input wire logic [25:0] i_page, // fetch address page
  input wire logic [25:0] d_page, // data address page
  input wire logic d_write, // data access is a store
  output logic i_fault, // fetch not permitted
  output logic d_fault // data access not permitted
);
  logic [25:0] origin_q [`MRA_ENTRIES];
  logic [25:0] bound_q [`MRA_ENTRIES];
  logic cache_q [`MRA_ENTRIES];
  logic [2:0] rights_q [`MRA_ENTRIES];
  logic [`MRA_ENTRIES-1:0] hit;
  logic [`MRA_ENTRIES-1:0] ok;

  genvar k;
  generate
    for (k = 0; k < `MRA_ENTRIES; k++) begin : g_ent
      logic [25:0] pg;
      logic [2:0] r;
      always_ff @(posedge clk) begin
        if (srst) begin
          origin_q[k] <= `MRA_PG_ZERO;
          bound_q[k] <= `MRA_PG_ZERO;
          cache_q[k] <= 1'b0;
          rights_q[k] <= `MRA_RT_ZERO;
        end else if (wr_en && wr_idx == 4'(k)) begin
          origin_q[k] <= wr_origin;
          bound_q[k] <= wr_bound;
          cache_q[k] <= wr_cache;
          rights_q[k] <= wr_rights;
        end
      end
      assign pg = (k < `MRA_IREGIONS) ? i_page : d_page;
      assign r = rights_q[k];
      // zero size code or zero bound leaves a region unused
      assign hit[k] = (bound_q[k] != `MRA_PG_ZERO) && (limit_mode ?
        (pg >= origin_q[k] && pg < bound_q[k]) :
        ((pg & bound_q[k]) == (origin_q[k] & bound_q[k])));
      if (k < `MRA_IREGIONS) begin : g_i
        assign ok[k] = (r == `MRA_RT_2) || (r == `MRA_RT_1 && !user_mode);
      end else begin : g_d
        assign ok[k] = d_write ?
          ((r == `MRA_RT_6) || (!user_mode && (r == `MRA_RT_4 || r == `MRA_RT_5))) :
          ((r == `MRA_RT_2) || (r == `MRA_RT_5) || (r == `MRA_RT_6) ||
           (!user_mode && (r == `MRA_RT_1 || r == `MRA_RT_4)));
      end
    end
  endgenerate

  // lowest numbered matching region decides; no match faults
  always_comb begin
    i_fault = 1'b1;
    d_fault = 1'b1;
    for (int j = `MRA_IREGIONS - 1; j >= 0; j--) begin
      if (hit[j]) begin
        i_fault = !ok[j];
      end
      if (hit[j + `MRA_IREGIONS]) begin
        d_fault = !ok[j + `MRA_IREGIONS];
      end
    end
  end

  // indirect read port
  assign rd_origin = origin_q[rd_idx];
  assign rd_bound = bound_q[rd_idx];
  assign rd_cache = cache_q[rd_idx];
  assign rd_rights = rights_q[rd_idx];
endmodule
`default_nettype wire

// ===== mra_regs.svh
// offsets, field positions, encodings and reset values of the region access unit
`ifndef MRA_REGS_SVH
`define MRA_REGS_SVH
`define MRA_OFF_SEL 5'h00
`define MRA_OFF_ACE 5'h04
`define MRA_OFF_CFG 5'h08
`define MRA_OFF_CAUSE 5'h0c
`define MRA_OFF_BAD 5'h10
`define MRA_OFF_ERA 5'h14
`define MRA_PG_HI 31
`define MRA_PG_LO 6
`define MRA_SEL_D 5
`define MRA_SEL_IDX_HI 2
`define MRA_SEL_IDX_LO 0
`define MRA_ACE_C 5
`define MRA_ACE_RT_HI 4
`define MRA_ACE_RT_LO 2
`define MRA_ACE_RD 1
`define MRA_ACE_WR 0
`define MRA_CFG_PON 0
`define MRA_CFG_LIMIT 1
`define MRA_CAUSE_HI 4
`define MRA_CAUSE_LO 0
`define MRA_ENTRIES 16
`define MRA_IREGIONS 8
`define MRA_CAUSE_IREGION 5'h10
`define MRA_CAUSE_DREGION 5'h11
`define MRA_CAUSE_TRAP 5'h03
`define MRA_CAUSE_ILLEGAL 5'h05
`define MRA_CAUSE_MISALIGN 5'h06
`define MRA_CAUSE_RST 5'h00
`define MRA_EA_STEP 32'h0000_0004
`define MRA_ZERO32 32'h0000_0000
`define MRA_PG_ZERO 26'h000_0000
`define MRA_RT_ZERO 3'h0
`define MRA_RT_1 3'h1
`define MRA_RT_2 3'h2
`define MRA_RT_4 3'h4
`define MRA_RT_5 3'h5
`define MRA_RT_6 3'h6
`endif

// ===== mra_top.sv
// region access control: indirect region registers, checks and violation causes
//
// Contract
// - access-control write with write flag commits the selected region
// - write flag always reads back as zero
// - each region keeps origin, size or bound, cacheable flag, rights
// - select region, then read flag write loads both registers
// - after a region read, both registers show the loaded values
// - writing the select register alone fetches nothing
// - select region, then write flag write commits its attributes
// - region register writes do not flush the pipeline
// - unit leaves reset disabled
// - protection-on bit zero disables, one enables
// - debugger reaches all registers through the normal accesses
// - no protection checks while the processor is in debug
// - cause 16 for instruction, 17 for data violation, general vector
// - data violation records bad address; return address is executing pc plus 4
// - every instruction fetch is checked against instruction regions
// - instruction violation outranks trap, illegal, data-address; data lowest
// - read flag write triggers region read; read flag reads as zero
// - cacheable flag is zero for instruction regions
`timescale 1ns/100ps
`default_nettype none
`include "mra_regs.svh"
module mra_top (
  input wire logic clk, // core clock, 10 MHz
  input wire logic srst, // sync reset, active high
  input wire logic [4:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic i_req, // fetch to check
  input wire logic [31:0] i_addr, // fetch address
  input wire logic d_req, // data access to check
  input wire logic [31:0] d_addr, // data address
  input wire logic d_write, // data access is a store
  input wire logic [31:0] exec_pc, // pc of executing instruction
  input wire logic user_mode, // core in user mode
  input wire logic debug_mode, // core in debug
  input wire logic trap_req, // trap exception request
  input wire logic illegal_req, // illegal instruction request
  input wire logic misalign_req, // misaligned data address request
  output logic exc_valid, // exception taken, pulse
  output logic [4:0] exc_cause, // cause of taken exception
  output logic exc_general, // use general exception vector
  output logic [31:0] bad_addr, // faulting data address
  output logic [31:0] exception_return_addr, // return address
  output logic flush_req, // pipeline flush pulse
  output logic protection_on // unit enabled
);
  mra_pkg::mra_bus_state_type state_q;
  logic waitreq_q;
  logic [31:0] rdata_q, rdata_d;
  logic [25:0] sel_origin_q;
  logic sel_d_q;
  logic [2:0] sel_idx_q;
  logic [25:0] ace_bound_q;
  logic ace_cache_q;
  logic [2:0] ace_rights_q;
  logic pon_q, limit_q, flush_q, exc_q, gen_q;
  logic [4:0] cause_q, cause_d;
  logic [31:0] bad_q, era_q;
  logic take, acc_wr, wr_sel, wr_ace, wr_cfg, f_rd, f_wr, reg_write, reg_read;
  logic [25:0] st_origin, st_bound;
  logic st_cache, i_fault, d_fault, active, i_viol, d_viol;
  logic [2:0] st_rights;
  logic [3:0] cur_idx;

  // accepted write decode
  assign acc_wr = (state_q == mra_pkg::mra_bus_done) && avs_write;
  assign wr_sel = acc_wr && avs_address == `MRA_OFF_SEL;
  assign wr_ace = acc_wr && avs_address == `MRA_OFF_ACE;
  assign wr_cfg = acc_wr && avs_address == `MRA_OFF_CFG;
  assign f_rd = avs_writedata[`MRA_ACE_RD];
  assign f_wr = avs_writedata[`MRA_ACE_WR];
  assign reg_write = wr_ace && f_wr && !f_rd;
  assign reg_read = wr_ace && f_rd && !f_wr;
  assign cur_idx = {sel_d_q, sel_idx_q};

  // bus handshake: one stall cycle, then answer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= mra_pkg::mra_bus_idle;
      waitreq_q <= 1'b1;
    end else begin
      case (state_q)
        mra_pkg::mra_bus_idle: begin
          if (avs_read || avs_write) begin
            state_q <= mra_pkg::mra_bus_done;
            waitreq_q <= 1'b0;
          end
        end
        mra_pkg::mra_bus_done: begin
          state_q <= mra_pkg::mra_bus_idle;
          waitreq_q <= 1'b1;
        end
        default: begin
          state_q <= mra_pkg::mra_bus_idle;
          waitreq_q <= 1'b1;
        end
      endcase
    end
  end

  // read data mux; unmapped reads as zero
  always_comb begin
    rdata_d = `MRA_ZERO32;
    case (avs_address)
      `MRA_OFF_SEL: begin
        rdata_d[`MRA_PG_HI:`MRA_PG_LO] = sel_origin_q;
        rdata_d[`MRA_SEL_D] = sel_d_q;
        rdata_d[`MRA_SEL_IDX_HI:`MRA_SEL_IDX_LO] = sel_idx_q;
      end
      `MRA_OFF_ACE: begin
        rdata_d[`MRA_PG_HI:`MRA_PG_LO] = ace_bound_q;
        rdata_d[`MRA_ACE_C] = ace_cache_q;
        rdata_d[`MRA_ACE_RT_HI:`MRA_ACE_RT_LO] = ace_rights_q;
      end
      `MRA_OFF_CFG: begin
        rdata_d[`MRA_CFG_PON] = pon_q;
        rdata_d[`MRA_CFG_LIMIT] = limit_q;
      end
      `MRA_OFF_CAUSE: rdata_d[`MRA_CAUSE_HI:`MRA_CAUSE_LO] = cause_q;
      `MRA_OFF_BAD: rdata_d = bad_q;
      `MRA_OFF_ERA: rdata_d = era_q;
      default: rdata_d = `MRA_ZERO32;
    endcase
  end

  // read data captured as waitrequest falls
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= `MRA_ZERO32;
    end else if (state_q == mra_pkg::mra_bus_idle && avs_read) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sel_origin_q <= `MRA_PG_ZERO;
      sel_d_q <= 1'b0;
      sel_idx_q <= 3'h0;
    end else if (wr_sel) begin
      sel_origin_q <= avs_writedata[`MRA_PG_HI:`MRA_PG_LO];
      sel_d_q <= avs_writedata[`MRA_SEL_D];
      sel_idx_q <= avs_writedata[`MRA_SEL_IDX_HI:`MRA_SEL_IDX_LO];
    end else if (reg_read) begin
      sel_origin_q <= st_origin;
    end
  end

  // access-control register contents
  always_ff @(posedge clk) begin
    if (srst) begin
      ace_bound_q <= `MRA_PG_ZERO;
      ace_cache_q <= 1'b0;
      ace_rights_q <= `MRA_RT_ZERO;
    end else if (reg_read) begin
      ace_bound_q <= st_bound;
      ace_cache_q <= st_cache;
      ace_rights_q <= st_rights;
    end else if (wr_ace && !(f_rd && f_wr)) begin
      ace_bound_q <= avs_writedata[`MRA_PG_HI:`MRA_PG_LO];
      ace_cache_q <= avs_writedata[`MRA_ACE_C] && sel_d_q;
      ace_rights_q <= avs_writedata[`MRA_ACE_RT_HI:`MRA_ACE_RT_LO];
    end
  end

  // configuration: enable and bound mode
  always_ff @(posedge clk) begin
    if (srst) begin
      pon_q <= 1'b0;
      limit_q <= 1'b0;
    end else if (wr_cfg) begin
      pon_q <= avs_writedata[`MRA_CFG_PON];
      limit_q <= avs_writedata[`MRA_CFG_LIMIT];
    end
  end

  // flush pulse on flushing register writes only
  always_ff @(posedge clk) begin
    if (srst) begin
      flush_q <= 1'b0;
    end else begin
      flush_q <= wr_cfg;
    end
  end

  // region store and checkers
  // commit through store write port
  mra_region_store u_store (
    .clk(clk),
    .srst(srst),
    .wr_en(reg_write),
    .wr_idx(cur_idx),
    .wr_origin(sel_origin_q),
    .wr_bound(avs_writedata[`MRA_PG_HI:`MRA_PG_LO]),
    .wr_cache(avs_writedata[`MRA_ACE_C] && sel_d_q),
    .wr_rights(avs_writedata[`MRA_ACE_RT_HI:`MRA_ACE_RT_LO]),
    .rd_idx(cur_idx),
    .rd_origin(st_origin),
    .rd_bound(st_bound),
    .rd_cache(st_cache),
    .rd_rights(st_rights),
    .limit_mode(limit_q),
    .user_mode(user_mode),
    .i_page(i_addr[`MRA_PG_HI:`MRA_PG_LO]),
    .d_page(d_addr[`MRA_PG_HI:`MRA_PG_LO]),
    .d_write(d_write),
    .i_fault(i_fault),
    .d_fault(d_fault)
  );

  assign active = pon_q && !debug_mode;
  assign i_viol = active && i_req && i_fault;
  assign d_viol = active && d_req && d_fault;
  assign take = i_viol || trap_req || illegal_req || misalign_req || d_viol;

  always_comb begin
    if (i_viol) begin
      cause_d = `MRA_CAUSE_IREGION;
    end else if (trap_req) begin
      cause_d = `MRA_CAUSE_TRAP;
    end else if (illegal_req) begin
      cause_d = `MRA_CAUSE_ILLEGAL;
    end else if (misalign_req) begin
      cause_d = `MRA_CAUSE_MISALIGN;
    end else begin
      cause_d = `MRA_CAUSE_DREGION;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      exc_q <= 1'b0;
      gen_q <= 1'b0;
      cause_q <= `MRA_CAUSE_RST;
    end else begin
      exc_q <= take;
      gen_q <= take;
      if (take) begin
        cause_q <= cause_d;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bad_q <= `MRA_ZERO32;
      era_q <= `MRA_ZERO32;
    end else if (take) begin
      if (i_viol) begin
        era_q <= i_addr + `MRA_EA_STEP;
      end else begin
        era_q <= exec_pc + `MRA_EA_STEP;
      end
      if (!i_viol && !trap_req && !illegal_req) begin
        bad_q <= d_addr;
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = waitreq_q;
  assign exc_valid = exc_q;
  assign exc_cause = cause_q;
  assign exc_general = gen_q;
  assign bad_addr = bad_q;
  assign exception_return_addr = era_q;
  assign flush_req = flush_q;
  assign protection_on = pon_q;

  // accepted access-control writes
  sequence seq_ace_read;
    wr_ace && f_rd && !f_wr;
  endsequence
  sequence seq_ace_write;
    wr_ace && f_wr && !f_rd;
  endsequence
  sequence seq_ace_both;
    wr_ace && f_rd && f_wr;
  endsequence

  chk_ace_flags_zero: assert property (
    @(posedge clk) disable iff (srst)
    (avs_read && !avs_waitrequest && avs_address == `MRA_OFF_ACE)
      |-> (avs_readdata[`MRA_ACE_RD] == 1'b0 && avs_readdata[`MRA_ACE_WR] == 1'b0))
    else $error("access-control flags read back non-zero");
  chk_region_commit: assert property (
    @(posedge clk) disable iff (srst)
    seq_ace_write |=> (st_bound == $past(avs_writedata[`MRA_PG_HI:`MRA_PG_LO])
      && st_origin == $past(sel_origin_q)))
    else $error("region write not committed");
  chk_region_load: assert property (
    @(posedge clk) disable iff (srst)
    seq_ace_read |=> (ace_bound_q == $past(st_bound) && sel_origin_q == $past(st_origin)
      && ace_rights_q == $past(st_rights)))
    else $error("region read did not load registers");
  chk_sel_no_fetch: assert property (
    @(posedge clk) disable iff (srst)
    wr_sel |=> (sel_origin_q == $past(avs_writedata[`MRA_PG_HI:`MRA_PG_LO])
      && $stable(ace_bound_q)))
    else $error("select write fetched attributes");
  chk_no_flush: assert property (
    @(posedge clk) disable iff (srst)
    (wr_sel || wr_ace) |=> !flush_req)
    else $error("region register write flushed the pipeline");
  chk_both_flags: assert property (
    @(posedge clk) disable iff (srst)
    seq_ace_both |=> ($stable(ace_bound_q) && $stable(st_bound) && $stable(st_rights)))
    else $error("both flags changed region state");
  chk_reset_off: assert property (
    @(posedge clk)
    srst |=> !protection_on ##1 (!protection_on || $past(wr_cfg)))
    else $error("unit enabled after reset");
  chk_debug_bypass: assert property (
    @(posedge clk) disable iff (srst)
    (debug_mode && !trap_req && !illegal_req && !misalign_req) |=> !exc_valid)
    else $error("region check active during debug");
  chk_icause: assert property (
    @(posedge clk) disable iff (srst)
    i_viol |=> (exc_valid && exc_general && exc_cause == `MRA_CAUSE_IREGION
      && exception_return_addr == $past(i_addr) + `MRA_EA_STEP))
    else $error("instruction violation cause or return address wrong");
  chk_dcause: assert property (
    @(posedge clk) disable iff (srst)
    (d_viol && !i_viol && !trap_req && !illegal_req && !misalign_req)
      |=> (exc_cause == `MRA_CAUSE_DREGION && bad_addr == $past(d_addr)))
    else $error("data violation cause or bad address wrong");
  chk_icache_zero: assert property (
    @(posedge clk) disable iff (srst)
    (!sel_d_q && wr_ace) |=> !ace_cache_q)
    else $error("instruction region shows cacheable flag");
endmodule
`default_nettype wire

// ===== tb_mra_top.sv
// self-checking bench for the region access unit
`timescale 1ns/100ps
`default_nettype none
`include "mra_regs.svh"
module tb_mra_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, i_req, d_req, d_write;
  logic [31:0] avs_writedata, avs_readdata, i_addr, d_addr, exec_pc;
  logic user_mode, debug_mode, trap_req, illegal_req, misalign_req;
  logic exc_valid, exc_general, flush_req, protection_on;
  logic [4:0] exc_cause;
  logic [31:0] bad_addr, exception_return_addr;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int nfl = 0;
  // 10 MHz core clock
  always #50 clk = ~clk;
  mra_top DUT (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .i_req(i_req), .i_addr(i_addr), .d_req(d_req),
    .d_addr(d_addr), .d_write(d_write), .exec_pc(exec_pc), .user_mode(user_mode),
    .debug_mode(debug_mode), .trap_req(trap_req), .illegal_req(illegal_req),
    .misalign_req(misalign_req), .exc_valid(exc_valid), .exc_cause(exc_cause),
    .exc_general(exc_general), .bad_addr(bad_addr),
    .exception_return_addr(exception_return_addr), .flush_req(flush_req),
    .protection_on(protection_on));
  mra_core_model core (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .i_req(i_req), .i_addr(i_addr), .d_req(d_req),
    .d_addr(d_addr), .d_write(d_write), .exec_pc(exec_pc), .user_mode(user_mode),
    .debug_mode(debug_mode), .trap_req(trap_req), .illegal_req(illegal_req),
    .misalign_req(misalign_req));
  // cycle ceiling and flush pulse count
  always @(posedge clk) begin
    cyc++;
    if (flush_req === 1'b1) nfl++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    core.acc(1'b0, a, 32'h0000_0000, q);
    cmp(q, exp);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    core.acc(1'b1, a, d, q);
  endtask
  // exception outputs one edge after the cause cycle
  task automatic exc(input logic v, input logic [4:0] c, input logic [31:0] era);
    #1;
    cmp({31'h0, exc_valid}, {31'h0, v});
    if (v) begin
      cmp({27'h0, exc_cause}, {27'h0, c});
      cmp({31'h0, exc_general}, 32'h0000_0001);
      cmp(exception_return_addr, era);
    end
  endtask
  task automatic t_reset;
    cmp({31'h0, protection_on}, 32'h0000_0000);
    rd(`MRA_OFF_CFG, 32'h0000_0000);
    rd(`MRA_OFF_ACE, 32'h0000_0000);
    wr(`MRA_OFF_CAUSE, 32'hffff_ffff);
    rd(`MRA_OFF_CAUSE, 32'h0000_0000);
    rd(5'h18, 32'h0000_0000);
  endtask
  task automatic t_rw;
    core.region(32'h1234_5623, 32'hfff0_0039);
    rd(`MRA_OFF_SEL, 32'h1234_5623);
    rd(`MRA_OFF_ACE, 32'hfff0_0038);
    wr(`MRA_OFF_SEL, 32'h0000_0023);
    rd(`MRA_OFF_SEL, 32'h0000_0023);
    wr(`MRA_OFF_ACE, 32'h0000_0040);
    rd(`MRA_OFF_ACE, 32'h0000_0040);
    wr(`MRA_OFF_ACE, 32'h0000_0002);
    rd(`MRA_OFF_SEL, 32'h1234_5623);
    rd(`MRA_OFF_ACE, 32'hfff0_0038);
  endtask
  task automatic t_flags;
    core.region(32'h0000_0041, 32'h0000_0025);
    rd(`MRA_OFF_ACE, 32'h0000_0004);
    core.region(32'h0000_0001, 32'h0000_0002);
    rd(`MRA_OFF_SEL, 32'h0000_0041);
    rd(`MRA_OFF_ACE, 32'h0000_0004);
    core.region(32'h0000_0023, 32'h0000_00ff);
    rd(`MRA_OFF_ACE, 32'h0000_0004);
    wr(`MRA_OFF_ACE, 32'h0000_0002);
    rd(`MRA_OFF_ACE, 32'hfff0_0038);
    rd(`MRA_OFF_SEL, 32'h1234_5623);
  endtask
  task automatic t_flush;
    int n0;
    n0 = nfl;
    core.region(32'h0000_0022, 32'h0000_0001);
    repeat (3) @(posedge clk);
    cmp(32'(nfl - n0), 32'h0000_0000);
    wr(`MRA_OFF_CFG, 32'h0000_0000);
    repeat (3) @(posedge clk);
    cmp(32'(nfl - n0), 32'h0000_0001);
  endtask
  task automatic t_prot;
    core.region(32'h0000_0000, 32'hffff_fc09);
    core.region(32'h0000_0020, 32'hffff_fc19);
    wr(`MRA_OFF_CFG, 32'h0000_0001);
    core.ex(1'b1, 32'h0000_0100, 1'b0, 32'h0, 3'h0, 1'b0);
    exc(1'b0, 5'h00, 32'h0);
    core.ex(1'b1, 32'h0000_8000, 1'b0, 32'h0, 3'h0, 1'b0);
    exc(1'b1, 5'h10, 32'h0000_8004);
    core.ex(1'b0, 32'h0, 1'b1, 32'h0000_8000, 3'h0, 1'b0);
    exc(1'b1, 5'h11, 32'h0000_0204);
    cmp(bad_addr, 32'h0000_8000);
    core.ex(1'b0, 32'h0, 1'b1, 32'h0000_0080, 3'h0, 1'b0);
    exc(1'b0, 5'h00, 32'h0);
    core.ex(1'b1, 32'h0000_8000, 1'b0, 32'h0, 3'h4, 1'b0);
    exc(1'b1, 5'h10, 32'h0000_8004);
    core.ex(1'b0, 32'h0, 1'b1, 32'h0000_8000, 3'h4, 1'b0);
    exc(1'b1, 5'h03, 32'h0000_0204);
    core.ex(1'b1, 32'h0000_8000, 1'b1, 32'h0000_8000, 3'h0, 1'b1);
    exc(1'b0, 5'h00, 32'h0);
    cmp({31'h0, protection_on}, 32'h0000_0001);
    rd(`MRA_OFF_CFG, 32'h0000_0001);
    wr(`MRA_OFF_CFG, 32'h0000_0000);
    core.ex(1'b1, 32'h0000_8000, 1'b0, 32'h0, 3'h0, 1'b0);
    exc(1'b0, 5'h00, 32'h0);
    cmp({31'h0, protection_on}, 32'h0000_0000);
  endtask
  // bound mode, user rights, stores, illegal and misalign requests
  task automatic t_modes;
    core.region(32'h0000_1000, 32'h0000_1409);
    core.region(32'h0000_0020, 32'hffff_fc15);
    wr(`MRA_OFF_CFG, 32'h0000_0003);
    rd(`MRA_OFF_CFG, 32'h0000_0003);
    core.ex(1'b1, 32'h0000_1000, 1'b0, 32'h0, 3'h0, 1'b0);
    exc(1'b0, 5'h00, 32'h0);
    core.ex(1'b1, 32'h0000_1800, 1'b0, 32'h0, 3'h0, 1'b0);
    exc(1'b1, 5'h10, 32'h0000_1804);
    core.mode(1'b1, 1'b1);
    core.ex(1'b0, 32'h0, 1'b1, 32'h0000_8000, 3'h2, 1'b0);
    exc(1'b1, 5'h05, 32'h0000_0204);
    core.ex(1'b0, 32'h0, 1'b1, 32'h0000_8000, 3'h0, 1'b0);
    exc(1'b1, 5'h11, 32'h0000_0204);
    core.mode(1'b1, 1'b0);
    core.ex(1'b0, 32'h0, 1'b1, 32'h0000_8000, 3'h0, 1'b0);
    exc(1'b0, 5'h00, 32'h0);
    core.mode(1'b0, 1'b1);
    core.ex(1'b0, 32'h0, 1'b1, 32'h0000_8000, 3'h0, 1'b0);
    exc(1'b0, 5'h00, 32'h0);
    core.ex(1'b0, 32'h0, 1'b0, 32'h0000_1234, 3'h1, 1'b0);
    exc(1'b1, 5'h06, 32'h0000_0204);
    cmp(bad_addr, 32'h0000_1234);
  endtask
  task automatic end_sim;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // reset, then scenarios in turn
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rw();
    t_flags();
    t_flush();
    t_prot();
    t_modes();
    end_sim();
  end
endmodule
`default_nettype wire
